// file: tb/pwr_monitor.sv
`include "pwr_defs.svh"

module pwr_monitor #(
  parameter int NPORT = 4
) (
  // Clock and reset
  input wire logic             clk,
  input wire logic             arst_n,
  // Power controls
  input wire logic             pll_en,
  input wire logic             mac_en,
  input wire logic             host_en,
  input wire logic [NPORT-1:0] phy_ed_only,
  input wire logic             ed_pulse,
  input wire logic             soft_rst,
  input wire logic [NPORT-1:0] cable_energy,
  // Media interface
  input wire logic             mac_crs,
  input wire pwr_pkg::mii_rx_t mac_rx,
  input wire logic             partner_idle_flag,
  input wire pwr_pkg::mii_tx_t phy_tx,
  input wire pwr_pkg::mii_rx_t phy_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  import pwr_pkg::*;

  localparam mii_tx_t LPI_TX = '{en: 1'h0, er: 1'h1, d: `TXD_LPI};
  localparam mii_rx_t LPI_RX = '{dv: 1'h0, er: 1'h1, d: `RXD_LPI};

  // Pulse width counted here, too long for a repetition
  logic [4:0] hi_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_q <= 5'h0;
    end else if (ed_pulse) begin
      hi_q <= hi_q + 5'h1;
    end else begin
      hi_q <= 5'h0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_off_group;
    !pll_en |-> !mac_en && !host_en;
  endproperty
  a_off_group: assert property (p_off_group)
    else $error("mac or host on with pll off");

  property p_wake_norm;
    $rose(soft_rst) |-> pll_en && mac_en;
  endproperty
  a_wake_norm: assert property (p_wake_norm)
    else $error("internal reset without normal mode");

  property p_pulse_len;
    // A wake may cut a pulse short; only full pulses are measured
    $fell(ed_pulse) && phy_ed_only != '0 |-> hi_q == 5'h0C;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("pulse width wrong");

  property p_pulse_low;
    ed_pulse |-> !pll_en && phy_ed_only != '0;
  endproperty
  a_pulse_low: assert property (p_pulse_low)
    else $error("pulse outside low state");

  property p_energy_wake;
    (|cable_energy) [*5] |-> phy_ed_only == '0;
  endproperty
  a_energy_wake: assert property (p_energy_wake)
    else $error("energy did not wake");

  property p_lpi_code;
    $rose(mac_crs) |=> phy_tx == LPI_TX;
  endproperty
  a_lpi_code: assert property (p_lpi_code)
    else $error("no assert code after request");

  property p_crs_defer;
    phy_tx == LPI_TX |-> mac_crs;
  endproperty
  a_crs_defer: assert property (p_crs_defer)
    else $error("carrier sense low during idle");

  property p_wake_hold;
    $past(phy_tx) == LPI_TX && phy_tx != LPI_TX |-> mac_crs [*8];
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("mac released too early");

  property p_rx_flag;
    (phy_rx == LPI_RX) [*5] |-> partner_idle_flag && mac_rx == '0;
  endproperty
  a_rx_flag: assert property (p_rx_flag)
    else $error("partner idle not shown");

  property p_rx_clear;
    (phy_rx != LPI_RX) [*5] |-> !partner_idle_flag;
  endproperty
  a_rx_clear: assert property (p_rx_clear)
    else $error("partner idle not cleared");

  c_lpi: cover property ($rose(mac_crs));
  c_pulse: cover property ($fell(ed_pulse));
  c_flag: cover property ($rose(partner_idle_flag));
endmodule

// file: tb/pwr_phy_model.sv
`include "pwr_defs.svh"

module pwr_phy_model (
  // Clock and reset
  input wire logic         clk,
  input wire logic         arst_n,
  // Commands from bench
  input wire logic         adv,
  input wire logic         lpi_on,
  input wire logic         send,
  // Toward the switch
  output logic             partner_eee,
  output pwr_pkg::mii_rx_t phy_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  import pwr_pkg::*;

  logic [3:0] cnt_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
      partner_eee <= 1'h0;
      phy_rx <= '0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      partner_eee <= adv;
      if (lpi_on) begin
        phy_rx <= '{dv: 1'h0, er: 1'h1, d: `RXD_LPI};
      end else begin
        // Nibble keeps moving when idle so nothing stale looks valid
        phy_rx <= '{dv: send, er: 1'h0, d: send ? cnt_q : ~cnt_q};
      end
    end
  end
endmodule

// file: tb/tb_top.sv
`include "pwr_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pwr_pkg::*;

  typedef struct packed {
    logic [1:0] m;
    logic       en;
    logic [1:0] mode;
  } row_t;

  // Written mode, expected enables, expected mode
  localparam row_t ROWS [4] = '{'{2'h1, 1'h0, 2'h1}, '{2'h3, 1'h0, 2'h1},
                                '{2'h0, 1'h1, 2'h0}, '{2'h3, 1'h1, 2'h0}};

  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, se;
  logic pll_en, mac_en, host_en, ed_pulse, soft_rst, partner_eee;
  logic mac_tx_pend, mac_crs, partner_idle_flag, adv, lpi_on, send;
  logic mac_tx_clk_en, mac_rx_clk_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  phy_pwr, phy_ed_only, cable_energy;
  mii_tx_t     mac_tx, phy_tx;
  mii_rx_t     mac_rx, phy_rx;
  int          err_total, check_count;

  pwr_ctrl #(.SEC_CYC(200), .TICK_CYC(10)) dut_u (.clk, .arst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pll_en,
    .mac_en, .host_en, .phy_pwr, .phy_ed_only, .ed_pulse, .soft_rst,
    .cable_energy, .partner_eee, .mac_tx, .mac_tx_pend, .mac_crs, .mac_rx,
    .partner_idle_flag, .mac_tx_clk_en, .mac_rx_clk_en, .phy_tx, .phy_rx);

  pwr_phy_model phy_u (.clk, .arst_n, .adv, .lpi_on, .send, .partner_eee,
    .phy_rx);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    // Waits out any stall; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done;
  end

  initial begin
    int n;
    {arst_n, psel, penable, pwrite, mac_tx_pend, adv, lpi_on, send} = '0;
    {paddr, pwdata, cable_energy, mac_tx} = '0;
    err_total = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    chk("en", {pll_en, mac_en, host_en, phy_pwr}, 7'h7F);
    apb(1'h0, `ADDR_SLEEP, 32'h0);
    chk("sleep", rd, `SLEEP_RST);
    apb(1'h0, `ADDR_PWR, 32'h0);
    chk("mode", rd, 32'h0);
    apb(1'h0, 8'h40, 32'h0);
    chk("err", se, 32'h1);
    chk("rd0", rd, 32'h0);
    foreach (ROWS[i]) begin
      apb(1'h1, `ADDR_PWR, {27'h0, ROWS[i].m, 3'h0});
      apb(1'h0, `ADDR_STAT, 32'h0);
      chk("mode", rd[5:4], ROWS[i].mode);
      chk("en", {pll_en, mac_en, host_en}, {3{ROWS[i].en}});
    end
    apb(1'h1, `ADDR_SLEEP, 32'h2);
    apb(1'h1, `ADDR_PWR, 32'h8);
    n = 0;
    while (phy_ed_only !== 4'hF && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("edlow", {phy_ed_only, pll_en}, 5'h1E);
    chk("edtime", n > 30 && n < 45, 32'h1);
    n = 0;
    while (ed_pulse !== 1'h1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (ed_pulse === 1'h1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk("pulse", n, 32'hC);
    cable_energy <= 4'h1;
    repeat (5) @(posedge clk);
    chk("edwake", phy_ed_only, 32'h0);
    apb(1'h1, `ADDR_PWR, 32'h0);
    apb(1'h1, `ADDR_PORT + 8'h4, 32'h8);
    apb(1'h1, `ADDR_PHY + 8'h8, 32'h800);
    chk("pd", phy_pwr, 32'h9);
    apb(1'h1, `ADDR_SLEEP, 32'h3);
    apb(1'h1, `ADDR_PWR, 32'h10);
    chk("soft", {pll_en, mac_en, phy_pwr}, 32'h0);
    apb(1'h1, `ADDR_SLEEP, 32'h55);
    repeat (3) @(posedge clk);
    chk("woke", {pll_en, host_en, phy_pwr}, 32'h3F);
    apb(1'h0, `ADDR_SLEEP, 32'h0);
    chk("sleep", rd, `SLEEP_RST);
    apb(1'h1, `ADDR_EEE, 32'h401);
    repeat (30) @(posedge clk);
    chk("noeee", mac_crs, 32'h0);
    adv <= 1'h1;
    n = 0;
    while (mac_crs !== 1'h1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    chk("lpi", phy_tx, {2'h1, `TXD_LPI});
    chk("gate", mac_tx_clk_en, 32'h0);
    mac_tx_pend <= 1'h1;
    // Request seen, state moves, then the registered code follows
    repeat (3) @(posedge clk);
    chk("wakecode", phy_tx, 32'h0);
    n = 0;
    while (mac_crs === 1'h1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk("wakelen", n > 2990 && n < 3003, 32'h1);
    lpi_on <= 1'h1;
    repeat (6) @(posedge clk);
    chk("flag", {partner_idle_flag, mac_rx}, 32'h40);
    chk("rxgate", mac_rx_clk_en, 32'h0);
    chk("txon", mac_crs, 32'h0);
    lpi_on <= 1'h0;
    send <= 1'h1;
    mac_tx <= '{en: 1'h1, er: 1'h0, d: 4'hA};
    repeat (6) @(posedge clk);
    chk("pass", {partner_idle_flag, mac_rx.dv}, 32'h1);
    chk("txpass", phy_tx, 32'h2A);
    test_done;
  end
endmodule

bind pwr_ctrl pwr_monitor #(.NPORT(NPORT)) mon_u (.clk, .arst_n, .pll_en,
  .mac_en, .host_en, .phy_ed_only, .ed_pulse, .soft_rst, .cable_energy,
  .mac_crs, .mac_rx, .partner_idle_flag, .phy_tx, .phy_rx);

// file: verilog/pwr_ctrl.sv
// Decided for this implementation: the APB register port and the placing of the registers.
`include "pwr_defs.svh"

module pwr_ctrl #(
  parameter int NPORT    = 4,
  parameter int AW       = 8,
  parameter int SEC_CYC  = `SEC_NS / `CLK_NS,
  parameter int TICK_CYC = `TICK_NS / `CLK_NS
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [AW-1:0]       paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Power enables
  output logic                     pll_en,
  output logic                     mac_en,
  output logic                     host_en,
  output logic [NPORT-1:0]         phy_pwr,
  output logic [NPORT-1:0]         phy_ed_only,
  output logic                     ed_pulse,
  output logic                     soft_rst,
  // Cable energy and partner ability
  input  wire logic [NPORT-1:0]    cable_energy,
  input  wire logic                partner_eee,
  // MAC side
  input  wire pwr_pkg::mii_tx_t    mac_tx,
  input  wire logic                mac_tx_pend,
  output logic                     mac_crs,
  output pwr_pkg::mii_rx_t         mac_rx,
  output logic                     partner_idle_flag,
  output logic                     mac_tx_clk_en,
  output logic                     mac_rx_clk_en,
  // PHY side
  output pwr_pkg::mii_tx_t         phy_tx,
  input  wire pwr_pkg::mii_rx_t    phy_rx
);
  import pwr_pkg::*;

  localparam int PULSE_CYC =
    (`PULSE_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int WAKE_CYC = `WAKE_NS / `CLK_NS;
  localparam int SECW  = $clog2(SEC_CYC + 1);
  localparam int TICKW = $clog2(TICK_CYC + 1);
  localparam int WAKEW = $clog2(WAKE_CYC + 1);

  function automatic logic blk_hit(input logic [AW-1:0] a,
                                   input logic [AW-1:0] base);
    blk_hit = (a[AW-1:4] == base[AW-1:4]) &&
              (32'(a[3:2]) < NPORT) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic is_lpi(input mii_rx_t r);
    is_lpi = !r.dv && r.er && (r.d == `RXD_LPI);
  endfunction

  // Register state
  pwr_mode_t        mode_q;
  logic [7:0]       sleep_q;
  logic             eee_adv_q;
  logic [7:0]       idle_thr_q;
  logic [NPORT-1:0] port_pd_q;
  logic [NPORT-1:0] phy_pd_q;
  logic             soft_rst_q;
  logic [31:0]      rd_d;
  logic             err_d;
  logic [31:0]      prdata_q;
  logic             perr_q;

  logic wr_en;
  logic wake;
  assign wr_en = psel && penable && pwrite;
  // Any access in soft power-down counts as a wake
  assign wake  = psel && penable && (mode_q == MODE_SOFT);

  // Status wires
  ed_st_t   ed_q;
  tx_st_t   tx_q;
  logic     pidle_q;
  logic     eee_ok;

  // Wake pulse becomes a one-cycle internal reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wake;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= MODE_NORMAL;
    end else if (soft_rst_q || wake) begin
      mode_q <= MODE_NORMAL;
    end else if (wr_en && paddr == `ADDR_PWR &&
                 pwdata[`MODE_MSB:`MODE_LSB] != MODE_RSVD) begin
      mode_q <= pwr_mode_t'(pwdata[`MODE_MSB:`MODE_LSB]);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_q    <= `SLEEP_RST;
      eee_adv_q  <= `EEE_ADV_RST;
      idle_thr_q <= `IDLE_RST;
    end else if (soft_rst_q) begin
      sleep_q    <= `SLEEP_RST;
      eee_adv_q  <= `EEE_ADV_RST;
      idle_thr_q <= `IDLE_RST;
    end else if (wr_en && !wake) begin
      if (paddr == `ADDR_SLEEP) begin
        sleep_q <= pwdata[`SLEEP_MSB:0];
      end
      if (paddr == `ADDR_EEE) begin
        eee_adv_q  <= pwdata[`EEE_ADV_BIT];
        idle_thr_q <= pwdata[`IDLE_MSB:`IDLE_LSB];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_pd_q <= '0;
      phy_pd_q  <= '0;
    end else if (soft_rst_q) begin
      port_pd_q <= '0;
      phy_pd_q  <= '0;
    end else if (wr_en && !wake) begin
      if (blk_hit(paddr, `ADDR_PORT)) begin
        port_pd_q[paddr[3:2]] <= pwdata[`PORT_PD_BIT];
      end
      if (blk_hit(paddr, `ADDR_PHY)) begin
        phy_pd_q[paddr[3:2]] <= pwdata[`PHY_PD_BIT];
      end
    end
  end

  // Read data staged in the setup cycle so it comes from a flop
  always_comb begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    if (paddr == `ADDR_PWR) begin
      rd_d[`MODE_MSB:`MODE_LSB] = mode_q;
    end else if (paddr == `ADDR_SLEEP) begin
      rd_d[`SLEEP_MSB:0] = sleep_q;
    end else if (paddr == `ADDR_EEE) begin
      rd_d[`EEE_ADV_BIT] = eee_adv_q;
      rd_d[`IDLE_MSB:`IDLE_LSB] = idle_thr_q;
    end else if (paddr == `ADDR_STAT) begin
      rd_d[`ST_LOW_BIT]   = (ed_q == ED_LOW);
      rd_d[`ST_TXLPI_BIT] = (tx_q == TX_LPI);
      rd_d[`ST_PIDLE_BIT] = pidle_q;
      rd_d[`ST_EEEOK_BIT] = eee_ok;
      rd_d[`ST_MODE_MSB:`ST_MODE_LSB] = mode_q;
    end else if (blk_hit(paddr, `ADDR_PORT)) begin
      rd_d[`PORT_PD_BIT] = port_pd_q[paddr[3:2]];
    end else if (blk_hit(paddr, `ADDR_PHY)) begin
      rd_d[`PHY_PD_BIT] = phy_pd_q[paddr[3:2]];
    end else begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h0000_0000;
      perr_q   <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      perr_q   <= err_d;
    end
  end

  assign pready  = psel && penable;
  assign pslverr = psel && penable && perr_q;
  assign prdata  = prdata_q;
  assign soft_rst = soft_rst_q;

  // Pin synchronisers
  logic [NPORT-1:0] en_s1, en_s2;
  logic             pe_s1, pe_s2;
  mii_rx_t          rx_s1, rx_s2, rx_s3;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_s1 <= '0;
      en_s2 <= '0;
      pe_s1 <= 1'b0;
      pe_s2 <= 1'b0;
      rx_s1 <= '0;
      rx_s2 <= '0;
      rx_s3 <= '0;
    end else begin
      en_s1 <= cable_energy;
      en_s2 <= en_s1;
      pe_s1 <= partner_eee;
      pe_s2 <= pe_s1;
      rx_s1 <= phy_rx;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
    end
  end

  // Energy detect: ms ticks of no energy against the timeout
  logic             energy;
  logic [TICKW-1:0] tick_q;
  logic [8:0]       quiet_q;
  logic [SECW-1:0]  sec_q;
  assign energy = |en_s2;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_q  <= '0;
      quiet_q <= '0;
      ed_q    <= ED_AWAKE;
    end else if (mode_q != MODE_ED || energy) begin
      tick_q  <= '0;
      quiet_q <= '0;
      ed_q    <= ED_AWAKE;
    end else if (32'(tick_q) == TICK_CYC - 1) begin
      tick_q <= '0;
      if (quiet_q > {1'b0, sleep_q}) begin
        ed_q <= ED_LOW;
      end else begin
        quiet_q <= quiet_q + 9'h001;
      end
    end else begin
      tick_q <= tick_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_q    <= '0;
      ed_pulse <= 1'b0;
    // Drop with the wake itself, not a cycle after it
    end else if (ed_q != ED_LOW || mode_q != MODE_ED || energy) begin
      sec_q    <= '0;
      ed_pulse <= 1'b0;
    end else begin
      sec_q    <= (32'(sec_q) == SEC_CYC - 1) ? '0 : sec_q + 1'b1;
      ed_pulse <= (32'(sec_q) < PULSE_CYC);
    end
  end

  // Power enables; ED normal-power state keeps the PHY usable
  logic phy_base;
  assign pll_en  = (mode_q == MODE_NORMAL);
  assign mac_en  = (mode_q == MODE_NORMAL);
  assign host_en = (mode_q == MODE_NORMAL);
  assign phy_base = (mode_q == MODE_NORMAL) ||
                    (mode_q == MODE_ED && ed_q == ED_AWAKE);

  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      assign phy_pwr[p] = phy_base && !port_pd_q[p] &&
                          !phy_pd_q[p];
      assign phy_ed_only[p] = (ed_q == ED_LOW);
    end
  endgenerate

  // Transmit low-power idle
  logic [7:0]       idle_q;
  logic [WAKEW-1:0] wake_q;
  logic             tx_quiet;
  assign eee_ok   = eee_adv_q && pe_s2 && mac_en;
  assign tx_quiet = !mac_tx.en && !mac_tx_pend;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_q   <= TX_ACTIVE;
      idle_q <= '0;
      wake_q <= '0;
    end else begin
      case (tx_q)
        TX_ACTIVE: begin
          idle_q <= tx_quiet ? ((idle_q == 8'hFF) ? idle_q
                                : idle_q + 8'h01) : 8'h00;
          // Only between frames, never mid-frame
          if (eee_ok && tx_quiet && idle_q >= idle_thr_q) begin
            tx_q <= TX_LPI;
          end
        end
        TX_LPI: begin
          idle_q <= '0;
          if (mac_tx_pend || !eee_ok) begin
            tx_q   <= TX_WAKE;
            wake_q <= '0;
          end
        end
        TX_WAKE: begin
          if (32'(wake_q) >= WAKE_CYC - 1) begin
            tx_q <= TX_ACTIVE;
          end else begin
            wake_q <= wake_q + 1'b1;
          end
        end
        default: begin
          tx_q <= TX_ACTIVE;
        end
      endcase
    end
  end

  // Defer the MAC while asleep or waking; receive is separate
  assign mac_crs       = (tx_q != TX_ACTIVE);
  assign mac_tx_clk_en = (tx_q != TX_LPI);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phy_tx <= '0;
    end else if (tx_q == TX_LPI) begin
      phy_tx <= '{en: 1'b0, er: 1'b1, d: `TXD_LPI};
    end else if (tx_q == TX_WAKE) begin
      phy_tx <= '{en: 1'b0, er: 1'b0, d: `MII_IDLE_D};
    end else begin
      phy_tx <= mac_tx;
    end
  end

  // Receive detect: flag follows edges of the assert code
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pidle_q <= 1'b0;
    end else if (!is_lpi(rx_s2)) begin
      pidle_q <= 1'b0;
    end else if (!is_lpi(rx_s3)) begin
      pidle_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mac_rx <= '0;
    end else if (is_lpi(rx_s2)) begin
      mac_rx <= '{dv: 1'b0, er: 1'b0, d: `MII_IDLE_D};
    end else begin
      mac_rx <= rx_s2;
    end
  end

  assign partner_idle_flag = pidle_q;
  assign mac_rx_clk_en     = !pidle_q;

endmodule

// file: verilog/pwr_defs.svh
`ifndef PWR_DEFS_SVH
`define PWR_DEFS_SVH

// Register byte addresses
`define ADDR_PWR      8'h00
`define ADDR_SLEEP    8'h04
`define ADDR_EEE      8'h08
`define ADDR_STAT     8'h0C
`define ADDR_PORT     8'h10
`define ADDR_PHY      8'h20

// Field positions
`define MODE_LSB      3
`define MODE_MSB      4
`define SLEEP_MSB     7
`define EEE_ADV_BIT   0
`define IDLE_LSB      8
`define IDLE_MSB      15
`define PORT_PD_BIT   3
`define PHY_PD_BIT    11
`define ST_LOW_BIT    0
`define ST_TXLPI_BIT  1
`define ST_PIDLE_BIT  2
`define ST_EEEOK_BIT  3
`define ST_MODE_LSB   4
`define ST_MODE_MSB   5

// Reset values
`define SLEEP_RST     8'h10
`define IDLE_RST      8'h20
`define EEE_ADV_RST   1'b0

// MII low-power idle codes and normal idle nibble
`define TXD_LPI       4'h1
`define RXD_LPI       4'h1
`define MII_IDLE_D    4'h0

// Times in ns
`define CLK_NS        10
`define PULSE_NS      120
`define SEC_NS        1000000000
`define TICK_NS       1000000
`define WAKE_NS       30000

`endif

// file: verilog/pwr_pkg.sv
package pwr_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_ED     = 2'b01,
    MODE_SOFT   = 2'b10,
    MODE_RSVD   = 2'b11
  } pwr_mode_t;

  typedef enum logic {
    ED_AWAKE = 1'b0,
    ED_LOW   = 1'b1
  } ed_st_t;

  typedef enum logic [1:0] {
    TX_ACTIVE = 2'b00,
    TX_LPI    = 2'b01,
    TX_WAKE   = 2'b10
  } tx_st_t;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] d;
  } mii_tx_t;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] d;
  } mii_rx_t;

endpackage
